// ### rtl/eeprom_program_control.sv
// Data EEPROM control register, row latches and programming sequencer
// Function
// R1: Standby bit disables EEPROM and access.
// R2: Start bit in parallel mode programs row.
// R3: Start bit self-clears when programming ends.
// R4: Unloaded row bytes keep previous contents.
// R5: Parallel mode accepts up to eight row bytes.
// R6: Row is A5..A3; A2..A0 pick byte.
// R7: Parallel mode bit clears after each cycle.
// R8: Clearing parallel mode abandons loaded row.
// R9: Busy flag high throughout programming cycle.
// R10: Accesses during busy aborted; cycle completes.
// R11: Software polls busy before EEPROM access.
// R12: Enable bit must be set to program.
// R13: Writes with enable clear do nothing.
// R14: Start ignored unless enable and mode set.
// R15: Setting parallel mode clears row latches.
// R16: Control writes rejected while busy.
// R17: Stop instruction disables EEPROM immediately.
// R18: Byte write outside parallel mode programs byte.
`default_nettype none
module eeprom_program_control
   import eeprom_ctl_pkg::*;
#(
   parameter int PROG_TIME = PROG_CYCLES  // Cycles per byte pass and per row slot
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // Core data-space access
   input  wire logic [7:0] cpu_addr,
   input  wire logic [7:0] cpu_wdata,
   input  wire logic       cpu_wr,
   input  wire logic       cpu_rd,
   input  wire logic       eeprom_sel,
   input  wire logic       stop_exec,
   output logic      [7:0] cpu_rdata,
   // Cell array write port, read enable and power
   output logic      [5:0] cell_addr,
   output logic      [7:0] cell_wdata,
   output logic            cell_we,
   output logic            cell_rd_en,
   output logic            cell_power_on
);
   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (PROG_TIME < 1 || PROG_TIME > 65535) begin : g_bad_time
      $error("PROG_TIME out of range");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic        enable_q;            // Programming enable
   logic        par_mode_q;          // Parallel mode
   logic        par_start_q;         // Parallel start
   logic        standby_q;           // Standby disable
   logic        stopped_q;           // Stop seen, cells off
   logic [7:0]  row_data_q [8];      // Volatile row latches
   logic [7:0]  row_valid_q;         // Which latches were loaded
   logic [2:0]  row_tag_q;           // Row number A5..A3 in window
   logic        row_locked_q;        // Row address latched
   prog_state_t state_q;             // Sequencer state
   logic [15:0] timer_q;             // Cycle timer
   logic [3:0]  slot_q;              // Row byte being written
   logic [5:0]  byte_addr_q;         // Single-byte target
   logic [7:0]  byte_data_q;         // Single-byte data

   logic busy;
   logic ctrl_wr;
   logic ee_wr;
   logic ee_live;

   // Window hit on the EEPROM page
   function automatic logic in_window(input logic [7:0] a);
      return a <= WIN_LAST;
   endfunction : in_window

   assign busy    = (state_q != ST_IDLE);
   // R1 standby gating: disabled cells answer nothing
   assign ee_live = !standby_q && !stopped_q;
   // R16 busy lock: control register frozen while programming
   assign ctrl_wr = cpu_wr && cpu_addr == CTRL_ADDR && !busy;
   // R10 busy abort: EEPROM accesses dropped during a cycle
   assign ee_wr   = cpu_wr && eeprom_sel && in_window(cpu_addr)
                    && !busy && ee_live;

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Write-only bits latched here; start needs enable and mode
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         enable_q    <= 1'b0;
         par_mode_q  <= 1'b0;
         par_start_q <= 1'b0;
         standby_q   <= 1'b0;
      end else if (ctrl_wr) begin
         enable_q    <= cpu_wdata[BIT_ENABLE];
         par_mode_q  <= cpu_wdata[BIT_PAR_MODE];
         standby_q   <= cpu_wdata[BIT_STANDBY];
         // R14 start guard: needs enable and mode already set
         par_start_q <= cpu_wdata[BIT_PAR_START] && enable_q
                        && par_mode_q && cpu_wdata[BIT_PAR_MODE]
                        && row_locked_q;
      end else if (state_q == ST_ROW && timer_q == 16'(PROG_TIME - 1)
                   && slot_q == 4'h7) begin
         // R3 start self-clear at end of row cycle
         par_start_q <= 1'b0;
         // R7 mode self-clear at end of row cycle
         par_mode_q  <= 1'b0;
      end
   end

   // Stop latch; only a reset wakes the cells again
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stopped_q <= 1'b0;
      end else if (stop_exec) begin
         // R17 stop disable
         stopped_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Row latches
   // ----------------------------------------------------------------
   // Only loaded bytes are marked; the rest stay untouched later
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         row_valid_q  <= 8'h00;
         row_tag_q    <= 3'h0;
         row_locked_q <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            row_data_q[i] <= 8'h00;
         end
      end else if (ctrl_wr && cpu_wdata[BIT_PAR_MODE] && !par_mode_q) begin
         // R15 fresh mode clears latches
         row_valid_q  <= 8'h00;
         row_locked_q <= 1'b0;
      end else if (ctrl_wr && !cpu_wdata[BIT_PAR_MODE]) begin
         // R8 abandon row when mode cleared early
         row_valid_q  <= 8'h00;
         row_locked_q <= 1'b0;
      end else if (ee_wr && par_mode_q && !par_start_q && enable_q) begin
         // R5 row load; R6 A5..A3 fixed after first byte
         if (!row_locked_q || row_tag_q == cpu_addr[5:3]) begin
            row_data_q[cpu_addr[2:0]]  <= cpu_wdata;
            row_valid_q[cpu_addr[2:0]] <= 1'b1;
            row_tag_q                  <= cpu_addr[5:3];
            row_locked_q               <= 1'b1;
         end
      end else if (state_q == ST_ROW && timer_q == 16'(PROG_TIME - 1)
                   && slot_q == 4'h7) begin
         // R7 pass done: latches dropped with the mode bit
         row_valid_q  <= 8'h00;
         row_locked_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Programming sequencer
   // ----------------------------------------------------------------
   // Row pass walks all eight slots, writing only loaded ones
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q     <= ST_IDLE;
         timer_q     <= 16'h0000;
         slot_q      <= 4'h0;
         byte_addr_q <= 6'h00;
         byte_data_q <= 8'h00;
      end else begin
         case (state_q)
            ST_IDLE: begin
               timer_q <= 16'h0000;
               slot_q  <= 4'h0;
               if (ctrl_wr && cpu_wdata[BIT_PAR_START] && enable_q
                   && par_mode_q && cpu_wdata[BIT_PAR_MODE]
                   && row_locked_q) begin
                  // R2 row start
                  state_q <= ST_ROW;
               end else if (ee_wr && enable_q && !par_mode_q) begin
                  // R18 single byte; R12 needs enable, R13 else nothing
                  state_q     <= ST_BYTE;
                  byte_addr_q <= cpu_addr[5:0];
                  byte_data_q <= cpu_wdata;
               end
            end
            ST_BYTE: begin
               if (timer_q == 16'(PROG_TIME - 1)) begin
                  state_q <= ST_IDLE;
               end else begin
                  timer_q <= timer_q + 16'h0001;
               end
            end
            ST_ROW: begin
               if (timer_q == 16'(PROG_TIME - 1)) begin
                  timer_q <= 16'h0000;
                  if (slot_q == 4'h7) begin
                     state_q <= ST_IDLE;
                  end else begin
                     slot_q <= slot_q + 4'h1;
                  end
               end else begin
                  timer_q <= timer_q + 16'h0001;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all registered
   // ----------------------------------------------------------------
   // Commit pulse at end of a byte pass and of each loaded row slot
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cell_we    <= 1'b0;
         cell_addr  <= 6'h00;
         cell_wdata <= 8'h00;
      end else begin
         cell_we <= 1'b0;
         if (state_q == ST_BYTE && timer_q == 16'(PROG_TIME - 1)) begin
            cell_we    <= 1'b1;
            cell_addr  <= byte_addr_q;
            cell_wdata <= byte_data_q;
         end else if (state_q == ST_ROW
                      && timer_q == 16'(PROG_TIME - 1)) begin
            // R4 unloaded bytes skipped
            cell_we    <= row_valid_q[slot_q[2:0]];
            cell_addr  <= {row_tag_q, slot_q[2:0]};
            cell_wdata <= row_data_q[slot_q[2:0]];
         end
      end
   end

   // Read data and power; busy is the only readable status bit
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cpu_rdata     <= CTRL_RESET;
         cell_rd_en    <= 1'b0;
         cell_power_on <= 1'b0;
      end else begin
         // R9 busy status
         cpu_rdata     <= {6'h00, busy, 1'b0};
         cell_rd_en    <= cpu_rd && eeprom_sel && in_window(cpu_addr)
                          && !busy && ee_live && !par_mode_q;
         cell_power_on <= ee_live && !(stop_exec);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_busy_blocks_ctrl: assert property (  // R16
      @(posedge sys_clk) disable iff (sys_rst)
      busy && cpu_wr && cpu_addr == CTRL_ADDR |=> $stable(enable_q))
      else $error("control changed while busy");
   chk_byte_needs_enable: assert property (  // R13
      @(posedge sys_clk) disable iff (sys_rst)
      ee_wr && !enable_q |=> state_q == ST_IDLE)
      else $error("write started without enable");
   chk_mode_clears_end: assert property (  // R7
      @(posedge sys_clk) disable iff (sys_rst)
      state_q == ST_ROW ##1 state_q == ST_IDLE |-> !par_mode_q)
      else $error("parallel mode left set");
   chk_start_clears_end: assert property (  // R3
      @(posedge sys_clk) disable iff (sys_rst)
      state_q == ST_ROW ##1 state_q == ST_IDLE |-> !par_start_q)
      else $error("start bit left set");
   chk_stop_power_off: assert property (  // R17
      @(posedge sys_clk) disable iff (sys_rst)
      stop_exec |=> !cell_power_on)
      else $error("power on after stop");
   chk_busy_readback: assert property (  // R9
      @(posedge sys_clk) disable iff (sys_rst)
      busy |=> cpu_rdata[BIT_BUSY])
      else $error("busy not reported");
   chk_row_start_guard: assert property (  // R14
      @(posedge sys_clk) disable iff (sys_rst)
      state_q == ST_IDLE && !enable_q |=> state_q != ST_ROW)
      else $error("row cycle without enable");
   chk_unloaded_kept: assert property (  // R4
      @(posedge sys_clk) disable iff (sys_rst)
      state_q == ST_ROW && timer_q == 16'(PROG_TIME - 1)
      && !row_valid_q[slot_q[2:0]] |=> !cell_we)
      else $error("unloaded byte written");
endmodule : eeprom_program_control
`default_nettype wire

// ### rtl/eeprom_ctl_pkg.sv
// Constants for the data EEPROM programming control block
`default_nettype none
package eeprom_ctl_pkg;
   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR       = 8'hEA; // Control register
   localparam int         BIT_ENABLE      = 0;     // Programming enable
   localparam int         BIT_BUSY        = 1;     // Busy flag
   localparam int         BIT_PAR_MODE    = 2;     // Parallel mode
   localparam int         BIT_PAR_START   = 3;     // Parallel start
   localparam int         BIT_STANDBY     = 6;     // Standby disable
   localparam logic [7:0] CTRL_RESET      = 8'h00; // Reset value
   localparam logic [7:0] WIN_LAST        = 8'h3F; // Top of EEPROM window
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ      = 10_000_000;        // Core clock rate
   localparam int PROG_US     = 5;                 // Default cycle time
   localparam int PROG_CYCLES = (PROG_US * (CLK_HZ / 1_000_000));
   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_BYTE  = 2'b01,
      ST_ROW   = 2'b10
   } prog_state_t;
endpackage : eeprom_ctl_pkg
`default_nettype wire

// ### dv/cpu_model.sv
// Core-side model issuing data-space reads and writes to the block
`default_nettype none
module cpu_model
   import eeprom_ctl_pkg::*;
(
   // Clock
   input  wire logic       sys_clk,
   // Data-space access
   output logic      [7:0] cpu_addr,
   output logic      [7:0] cpu_wdata,
   output logic            cpu_wr,
   output logic            cpu_rd,
   output logic            eeprom_sel,
   input  wire logic [7:0] cpu_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Bus idle state
   // ----------------------------------------------------------------
   // Page select stays on; bank switching is outside this block
   initial begin
      cpu_addr   = 8'h00;
      cpu_wdata  = 8'h00;
      cpu_wr     = 1'b0;
      cpu_rd     = 1'b0;
      eeprom_sel = 1'b1;
   end
   // One-cycle write strobe; released lines show the inverse value
   task automatic write_cyc(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #10;
      cpu_addr  = a;
      cpu_wdata = d;
      cpu_wr    = 1'b1;
      @(posedge sys_clk);
      #10;
      cpu_wr    = 1'b0;
      cpu_addr  = ~a;
      cpu_wdata = ~d;
   endtask : write_cyc
   // Read strobe; data taken just after the edge that takes it
   task automatic read_cyc(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      #10;
      cpu_addr = a;
      cpu_rd   = 1'b1;
      @(posedge sys_clk);
      #10;
      d        = cpu_rdata;
      cpu_rd   = 1'b0;
      cpu_addr = ~a;
   endtask : read_cyc
   // poll busy flag
   // Bounded so a stuck flag cannot hang the caller
   task automatic wait_ready(output logic done);
      logic [7:0] v;
      done = 1'b0;
      for (int i = 0; i < 100 && !done; i++) begin
         read_cyc(CTRL_ADDR, v);
         if (v === 8'h00) done = 1'b1;
      end
   endtask : wait_ready
endmodule : cpu_model
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the EEPROM programming control block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import eeprom_ctl_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int PT = 8;             // Short pass keeps the run brief
   logic        sys_clk = 1'b0;       // Core clock
   logic        sys_rst = 1'b1;       // Held over the first cycles
   logic        stop_exec = 1'b0;     // Stop instruction pulse
   logic [7:0]  cpu_addr, cpu_wdata, cpu_rdata;
   logic        cpu_wr, cpu_rd, eeprom_sel;
   logic [5:0]  cell_addr;
   logic [7:0]  cell_wdata, rd_v;
   logic        cell_we, cell_rd_en, cell_power_on, ok;
   logic [15:0] seed = 16'h66EC;      // Fixed start of the random stream
   logic [15:0] exp_q[$];             // Expected commits {addr, data}
   int          num_errors = 0;
   int          num_checks = 0;
   always #50 sys_clk = ~sys_clk;
   eeprom_program_control #(.PROG_TIME(PT)) i_eeprom_program_control (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
      .eeprom_sel(eeprom_sel), .stop_exec(stop_exec),
      .cpu_rdata(cpu_rdata), .cell_addr(cell_addr),
      .cell_wdata(cell_wdata), .cell_we(cell_we),
      .cell_rd_en(cell_rd_en), .cell_power_on(cell_power_on));
   cpu_model i_cpu_model (
      .sys_clk(sys_clk), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .eeprom_sel(eeprom_sel),
      .cpu_rdata(cpu_rdata));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction : rnd
   task automatic check_cm(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_cm
   task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_rd
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask : idle
   // Byte write that the model expects to be programmed
   task automatic put(input logic [7:0] a);
      logic [7:0] d;
      d = rnd();
      exp_q.push_back({a, d});
      i_cpu_model.write_cyc(a, d);
   endtask : put
   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // ----------------------------------------------------------------
   // Commit monitor: any commit not queued is a mismatch
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (cell_we === 1'b1) begin
         if (exp_q.size() == 0)
            check_cm({2'b00, cell_addr, cell_wdata}, 16'hFFFF);
         else
            check_cm({2'b00, cell_addr, cell_wdata}, exp_q.pop_front());
      end
   end
   // Run is a few hundred cycles; this span is ample
   initial begin
      #(3000 * 100);
      num_errors++;
      give_verdict();
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge sys_clk);
      #10 sys_rst = 1'b0;
      idle(1);
      check_rd(cpu_rdata, CTRL_RESET);
      i_cpu_model.write_cyc(8'h05, rnd());
      // Byte write, then control and cell writes while busy
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h01);
      put(8'h12);
      i_cpu_model.read_cyc(CTRL_ADDR, rd_v);
      check_rd(rd_v, 8'h02);
      check_rd({7'h00, cell_rd_en}, 8'h00);
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h40);
      i_cpu_model.write_cyc(8'h13, rnd());
      i_cpu_model.wait_ready(ok);
      check_rd({6'h00, ok, cell_power_on}, 8'h03);
      i_cpu_model.read_cyc(8'h12, rd_v);
      check_rd({7'h00, cell_rd_en}, 8'h01);
      // Partial row with a stray write to another row
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h05);
      put(8'h18);
      put(8'h1A);
      put(8'h1B);
      i_cpu_model.write_cyc(8'h20, rnd());
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h0D);
      i_cpu_model.read_cyc(CTRL_ADDR, rd_v);
      check_rd(rd_v, 8'h02);
      i_cpu_model.wait_ready(ok);
      check_cm({15'h0, ok}, 16'h0001);
      // Mode gone after the pass: byte mode again, start ignored
      put(8'h21);
      i_cpu_model.wait_ready(ok);
      check_cm({15'h0, ok}, 16'h0001);
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h09);
      // Row abandoned by dropping mode; fresh mode clears latches
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h05);
      i_cpu_model.write_cyc(8'h30, rnd());
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h04);
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h0C);
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h01);
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h05);
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h0D);
      idle(10 * PT);
      check_cm(16'(exp_q.size()), 16'h0000);
      // Standby, then wake, then the sticky stop
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h41);
      idle(2);
      check_rd({7'h00, cell_power_on}, 8'h00);
      i_cpu_model.write_cyc(8'h05, rnd());
      i_cpu_model.read_cyc(8'h05, rd_v);
      check_rd({7'h00, cell_rd_en}, 8'h00);
      i_cpu_model.write_cyc(CTRL_ADDR, 8'h01);
      idle(2);
      check_rd({7'h00, cell_power_on}, 8'h01);
      stop_exec = 1'b1;
      idle(1);
      stop_exec = 1'b0;
      idle(2);
      check_rd({7'h00, cell_power_on}, 8'h00);
      i_cpu_model.write_cyc(8'h07, rnd());
      idle(3 * PT);
      check_cm(16'(exp_q.size()), 16'h0000);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
